// *** dv/host_pins.sv ***
// host model driving master clear, time tag clock and inhibits
// assumes the bench calls its tasks; pins change just after sys_clk rises
`timescale 1ns/1ps
module host_pins (
	// clock
	input wire sys_clk,
	// pins toward the block
	output reg mclr_n = 1'b1,
	output reg tag_clk = 1'b0,
	output reg inh_a = 1'b0,
	output reg inh_b = 1'b0
);
task clear(input integer n);
	begin
		@(posedge sys_clk);
		mclr_n <= 1'b0;
		repeat (n) @(posedge sys_clk);
		mclr_n <= 1'b1;
	end
endtask
// high and low three cycles each, well above the sync needs
task tag_edge;
	begin
		@(posedge sys_clk);
		tag_clk <= 1'b1;
		repeat (3) @(posedge sys_clk);
		tag_clk <= 1'b0;
		repeat (3) @(posedge sys_clk);
	end
endtask
task inhibit(input a, input b);
	begin
		@(posedge sys_clk);
		inh_a <= a;
		inh_b <= b;
	end
endtask
endmodule

// *** dv/misc_pins_properties.sv ***
// assertions on the misc pin block, seeing its ports only
// assumes one sys_clk domain and an asynchronous arst_n
`timescale 1ns/1ps
module misc_pins_properties #(parameter TAG_WIDTH = 16) (
	// clock and resets
	input wire sys_clk,
	input wire arst_n,
	input wire master_clear_n,
	// watched ports
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire time_tag_clk,
	input wire tx_inhibit_chan_a,
	input wire tx_inhibit_chan_b,
	input wire message_in_progress_n,
	input wire tx_enable_chan_a,
	input wire tx_enable_chan_b,
	input wire [TAG_WIDTH-1:0] time_tag
);
// ----
// shadow of mode and source; quiet for a while after a clear
// ----
reg [1:0] md;
reg sel;
reg [3:0] qt;
wire ok = qt == 4'hF;
wire ev = reg_wr && reg_addr == 4'h2 && ok;
wire wt = reg_wr && reg_addr == 4'h3;
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		md <= 2'h0;
		sel <= 1'b0;
		qt <= 4'hF;
	end else if (!master_clear_n) begin
		md <= 2'h0;
		sel <= 1'b0;
		qt <= 4'h0;
	end else begin
		qt <= ok ? qt : qt + 4'h1;
		if (reg_wr && reg_addr == 4'h1)
			md <= reg_wdata[1:0];
		if (reg_wr && reg_addr == 4'h0)
			sel <= reg_wdata[9:7] == 3'h7;
	end
end
default clocking @(posedge sys_clk); endclocking
default disable iff (!arst_n);
a_inhibit_chan_a: assert property (tx_enable_chan_a |-> !$past(tx_inhibit_chan_a, 3))
	else $error("a sent while inhibited");
a_inhibit_chan_b: assert property (tx_enable_chan_b |-> !$past(tx_inhibit_chan_b, 3))
	else $error("b sent while inhibited");
a_tag_step: assert property ($changed(time_tag) && ok && !$past(wt) |->
	time_tag == $past(time_tag) + 1'b1) else $error("tag jump");
a_tag_source: assert property ($changed(time_tag) && ok && !$past(wt) |-> $past(sel) &&
	($past(time_tag_clk, 3) || $past(time_tag_clk, 4) || $past(time_tag_clk, 5)))
	else $error("tag moved unselected");
a_bc_busy: assert property (ev && md == 2'h0 && reg_wdata[0] |-> ##2 !message_in_progress_n)
	else $error("bc not busy");
a_rt_busy: assert property (ev && (md == 2'h1 || md == 2'h2) && reg_wdata[4] && !reg_wdata[1]
	|-> ##2 !message_in_progress_n) else $error("rt not busy");
a_mon_go: assert property (ev && md == 2'h3 && reg_wdata[2] && !reg_wdata[3]
	|-> ##2 !message_in_progress_n) else $error("monitor not busy");
a_mon_reset: assert property (ev && md == 2'h3 && reg_wdata[3] |-> ##2 message_in_progress_n)
	else $error("monitor still busy");
a_clear_all: assert property (!master_clear_n [*8] |=> time_tag == 0 && message_in_progress_n
	&& !tx_enable_chan_a && !tx_enable_chan_b) else $error("clear incomplete");
endmodule
bind misc_pins misc_pins_properties #(.TAG_WIDTH(TAG_WIDTH)) u_misc_pins_properties (
	.sys_clk(sys_clk), .arst_n(arst_n), .master_clear_n(master_clear_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .time_tag_clk(time_tag_clk),
	.tx_inhibit_chan_a(tx_inhibit_chan_a), .tx_inhibit_chan_b(tx_inhibit_chan_b),
	.message_in_progress_n(message_in_progress_n), .tx_enable_chan_a(tx_enable_chan_a),
	.tx_enable_chan_b(tx_enable_chan_b), .time_tag(time_tag));

// *** dv/tb_misc_pins.sv ***
// bench for misc_pins: register port, host pin model, queued read checks
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module tb_misc_pins;
reg sys_clk, arst_n, reg_wr, reg_rd;
reg rd_q = 1'b0;
reg [3:0] reg_addr;
reg [15:0] reg_wdata, v;
wire [15:0] reg_rdata, tag;
wire mclr_n, tclk, inh_a, inh_b, mip_n, en_a, en_b;
integer miscompares = 0, check_count = 0, cycles = 0, m;
reg [15:0] exp_q[$];
misc_pins u_misc_pins (.sys_clk(sys_clk), .arst_n(arst_n), .master_clear_n(mclr_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .time_tag_clk(tclk), .tx_inhibit_chan_a(inh_a),
	.tx_inhibit_chan_b(inh_b), .message_in_progress_n(mip_n), .tx_enable_chan_a(en_a),
	.tx_enable_chan_b(en_b), .time_tag(tag));
host_pins u_host_pins (.sys_clk(sys_clk), .mclr_n(mclr_n), .tag_clk(tclk),
	.inh_a(inh_a), .inh_b(inh_b));
initial begin
	sys_clk = 1'b0;
	forever #12.5 sys_clk = ~sys_clk;
end
task chk(input string nm, input [15:0] e, input [15:0] g);
	begin
		check_count = check_count + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	end
endtask
task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	end
endtask
task rd(input [3:0] a, input [15:0] e);
	begin
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	end
endtask
task settle(input integer n);
	begin
		repeat (n) @(posedge sys_clk);
		#1;
	end
endtask
task results;
	begin
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
endtask
// read data are due exactly one cycle after the strobe
always @(posedge sys_clk) begin
	if (rd_q)
		chk("rdata", exp_q.pop_front(), reg_rdata);
	rd_q <= reg_rd;
	cycles = cycles + 1;
	if (cycles == 2000) begin
		miscompares = miscompares + 1;
		results;
	end
end
initial begin
	{arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
	void'($urandom(24));
	repeat (3) @(posedge sys_clk);
	arst_n <= 1'b1;
	u_host_pins.clear(6);
	settle(8);
	rd(4'h0, 16'h0000);
	rd(4'h9, 16'h0000);
	for (m = 0; m < 3; m = m + 1) begin
		u_host_pins.inhibit(m == 0, m == 1);
		settle(4);
		chk("en_a", m != 0, en_a);
		chk("en_b", m != 1, en_b);
	end
	$display("inhibit test done");
	for (m = 0; m < 4; m = m + 1) begin
		wr(4'h1, m[15:0]);
		wr(4'h2, m == 0 ? 16'h0001 : m == 3 ? 16'h0004 : 16'h0010);
		settle(2);
		chk("busy", 1'b0, mip_n);
		wr(4'h2, m == 3 ? 16'h0008 : 16'h0002);
		settle(2);
		chk("idle", 1'b1, mip_n);
	end
	$display("message test done");
	v = 16'($urandom);
	wr(4'h3, v);
	wr(4'h0, 16'h0380);
	u_host_pins.tag_edge;
	u_host_pins.tag_edge;
	rd(4'h3, v + 16'h0002);
	wr(4'h0, 16'h0300);
	u_host_pins.tag_edge;
	rd(4'h3, v + 16'h0002);
	$display("time tag test done");
	wr(4'h0, 16'h0380);
	wr(4'h2, 16'h0004);
	settle(2);
	chk("busy", 1'b0, mip_n);
	u_host_pins.clear(10);
	settle(8);
	chk("idle", 1'b1, mip_n);
	rd(4'h0, 16'h0000);
	rd(4'h3, 16'h0000);
	settle(2);
	$display("clear test done");
	results;
end
endmodule

// *** rtl/misc_pins.v ***
// miscellaneous control pins: master clear, message-in-progress, time tag, inhibits
// assumes a 40 MHz sys_clk, synchronous register strobes, and event pulses from the
// protocol engines
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "misc_pins_map.vh"
module misc_pins #(
	parameter TAG_WIDTH = 16
) (
	// clock and resets
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire        master_clear_n,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// external pins
	input  wire        time_tag_clk,
	input  wire        tx_inhibit_chan_a,
	input  wire        tx_inhibit_chan_b,
	output reg         message_in_progress_n,
	// to transmitters
	output reg         tx_enable_chan_a,
	output reg         tx_enable_chan_b,
	// time tag value
	output reg  [TAG_WIDTH-1:0] time_tag
);

	// ----------------------------------------------------------------
	// master clear filter
	// ----------------------------------------------------------------
	// a low shorter than the minimum is ignored so glitches do not wipe state
	reg  [2:0] mclr_cnt;
	reg        soft_clear;
	wire       mclr_sync_n;

	sync_bit u_mclr_sync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.din    (master_clear_n),
		.dout   (mclr_sync_n)
	);

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mclr_cnt   <= 3'h0;
			soft_clear <= 1'b0;
		end else if (mclr_sync_n) begin
			mclr_cnt   <= 3'h0;
			soft_clear <= 1'b0;
		end else if (mclr_cnt < `MCLR_MIN_CYC - 1) begin
			mclr_cnt   <= mclr_cnt + 3'h1;
		end else begin
			soft_clear <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	wire tag_sync;
	wire inh_a_sync;
	wire inh_b_sync;

	sync_bit u_tag_sync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.din    (time_tag_clk),
		.dout   (tag_sync)
	);
	sync_bit u_inh_a_sync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.din    (tx_inhibit_chan_a),
		.dout   (inh_a_sync)
	);
	sync_bit u_inh_b_sync (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.din    (tx_inhibit_chan_b),
		.dout   (inh_b_sync)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [15:0] config2;
	reg [1:0]  mode;
	reg        tag_prev;
	reg        mon_online;
	reg        msg_active;

	wire       ev_wr  = reg_wr && (reg_addr == `REG_EVENT);
	wire [2:0] src    = config2[`CFG2_SRC_MSB:`CFG2_SRC_LSB];
	wire       tag_ext = (src == `SRC_EXT_TAG);
	wire       tag_rise = tag_sync && !tag_prev;

	// the counter widened to the bus word without a zero-width replication
	reg  [15:0] tag_word;

	always @* begin
		tag_word                = 16'h0000;
		tag_word[TAG_WIDTH-1:0] = time_tag;
	end

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			config2 <= `CFG2_RESET;
			mode    <= `MODE_BC;
		end else if (soft_clear) begin
			config2 <= `CFG2_RESET;
			mode    <= `MODE_BC;
		end else if (reg_wr) begin
			if (reg_addr == `REG_CONFIG2)
				config2 <= reg_wdata;
			if (reg_addr == `REG_MODE)
				mode <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// time tag counter
	// ----------------------------------------------------------------
	// counts only from the external clock; internal sources live elsewhere
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tag_prev <= 1'b0;
			time_tag <= {TAG_WIDTH{1'b0}};
		end else if (soft_clear) begin
			tag_prev <= 1'b0;
			time_tag <= {TAG_WIDTH{1'b0}};
		end else begin
			tag_prev <= tag_sync;
			if (reg_wr && reg_addr == `REG_TIME_TAG)
				time_tag <= reg_wdata[TAG_WIDTH-1:0];
			else if (tag_ext && tag_rise)
				time_tag <= time_tag + {{(TAG_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// message-in-progress
	// ----------------------------------------------------------------
	// event register bits are self-clearing pulses written by the engines
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			msg_active <= 1'b0;
			mon_online <= 1'b0;
		end else if (soft_clear) begin
			msg_active <= 1'b0;
			mon_online <= 1'b0;
		end else begin
			case (mode)
			`MODE_BC: begin
				mon_online <= 1'b0;
				if (ev_wr && reg_wdata[`EV_MSG_START])
					msg_active <= 1'b1;
				else if (ev_wr && reg_wdata[`EV_MSG_DONE])
					msg_active <= 1'b0;
			end
			`MODE_RT, `MODE_SEL_MON: begin
				mon_online <= 1'b0;
				if (ev_wr && reg_wdata[`EV_CMD_RECEIVED])
					msg_active <= 1'b1;
				else if (ev_wr && reg_wdata[`EV_MSG_DONE])
					msg_active <= 1'b0;
			end
			`MODE_WORD_MON: begin
				msg_active <= 1'b0;
				if (ev_wr && reg_wdata[`EV_MON_RESET])
					mon_online <= 1'b0;
				else if (ev_wr && reg_wdata[`EV_MON_GO])
					mon_online <= 1'b1;
			end
			default: begin
				msg_active <= 1'b0;
				mon_online <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			message_in_progress_n <= 1'b1;
			tx_enable_chan_a      <= 1'b0;
			tx_enable_chan_b      <= 1'b0;
			reg_rdata             <= 16'h0000;
		end else begin
			message_in_progress_n <= !(msg_active || mon_online);
			tx_enable_chan_a      <= !inh_a_sync && !soft_clear;
			tx_enable_chan_b      <= !inh_b_sync && !soft_clear;
			reg_rdata             <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
				`REG_CONFIG2:  reg_rdata <= config2;
				`REG_MODE:     reg_rdata <= {14'h0000, mode};
				`REG_TIME_TAG: reg_rdata <= tag_word;
				`REG_STATUS:   reg_rdata <= {11'h000, tag_ext, inh_b_sync, inh_a_sync,
				                             mon_online, msg_active};
				default:       reg_rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// *** rtl/misc_pins_map.vh ***
// constants for the terminal miscellaneous control and status pin logic
// assumes one system clock at 40 MHz and a plain strobe register port
// Operation
// - all logic runs from one system clock
// - master clear low resets to power-on state
// - bus controller: low through each message
// - terminal/selective monitor: low command to completion
// - word monitor: low after go, high after reset
// - selected time-tag clock edge advances counter
// - config two bits 7..9 choose counter source; here only value 7 counts, from time_tag_clk, other values hold it
// - each inhibit input disables its own transmitter
`ifndef MISC_PINS_MAP_VH
`define MISC_PINS_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CONFIG2        4'h0
`define REG_MODE           4'h1
`define REG_EVENT          4'h2
`define REG_TIME_TAG       4'h3
`define REG_STATUS         4'h4

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define CFG2_SRC_LSB       7
`define CFG2_SRC_MSB       9
`define CFG2_RESET         16'h0000
`define SRC_EXT_TAG        3'h7
`define MODE_BC            2'h0
`define MODE_RT            2'h1
`define MODE_SEL_MON       2'h2
`define MODE_WORD_MON      2'h3
`define EV_MSG_START       0
`define EV_MSG_DONE        1
`define EV_MON_GO          2
`define EV_MON_RESET       3
`define EV_CMD_RECEIVED    4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_CLK_MHZ        40
`define MCLR_MIN_NS        100
`define MCLR_MIN_CYC       ((`MCLR_MIN_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/sync_bit.v ***
// two-stage synchroniser for one level input
// assumes the input may change at any time relative to clk
`timescale 1ns/1ps
module sync_bit (
	// clock and reset
	input  wire clk,
	input  wire arst_n,
	// level in and out
	input  wire din,
	output reg  dout
);
	reg meta;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
